// ==== hw/sbt_session.sv ====
// target-side session keeper: status block encoding, reconnect after bus
// reset, automatic logout and login refusal during the reconnect window.
// assumes fetch/write engines outside take each one-cycle status and fetch
// pulse at once, and that all inputs are synchronous to core_clk.
//
// How it works
// - status field carries the fourteen transport codes
// - unsupported request gets complete, status one
// - command words copied only into five-quadlet blocks
// - good reconnect restarts host inactivity watchdog
// - bus reset with login starts reconnect timer
// - reconnect write speed becomes session speed
// - accept reconnect only on matching unique id
// - reconnect status goes to separate buffer
// - unsolicited status uses login status address
// - patch node and bus into stored addresses
// - timer expiry logs out, agents reinitialised
// - refuse new login inside reconnect window
// - every bus reset restarts inactivity watchdog
// - async phase resumes after reconnect
// - isochronous stream continues through bus reset
// - crc error acknowledgement forces retransmission
// - response code zero means request complete
// - block is two or five quadlets
// - unsolicited status only while permit set
`timescale 1ns/1ps
`default_nettype none
`include "sbt_defs.svh"

module sbt_session
	import sbt_pkg::*;
#(
	parameter int unsigned RECON_CYCLES = `SBT_RECON_MS * `SBT_CLK_KHZ
) (
	input  wire logic           core_clk,
	input  wire logic           rst,
	input  wire logic           bus_reset,
	input  wire logic           login_ok,
	input  wire sbt_login_type  login_info,
	input  wire logic           login_req,
	input  wire logic           recon_req,
	input  wire sbt_recon_type  recon_info,
	input  wire logic           guid_valid,
	input  wire logic [63:0]    host_guid,
	input  wire logic [15:0]    host_node,
	input  wire logic           orb_req,
	input  wire sbt_orb_type    orb_info,
	input  wire logic           permit_set,
	input  wire logic           unsol_req,
	input  wire logic           ack_crc_err,
	input  wire logic           iso_active,
	input  wire logic           async_active,
	output logic                status_valid,
	output sbt_status_type      status,
	output sbt_state_type       state,
	output logic [1:0]          speed,
	output logic [15:0]         data_node,
	output logic                guid_fetch,
	output logic                login_refused,
	output logic                logout,
	output logic                wd_restart,
	output logic                retransmit,
	output logic                async_resume,
	output logic                iso_continue
);

	localparam logic [31:0] RECON_LAST = 32'(RECON_CYCLES - 1);

	typedef struct packed {
		sbt_state_type  state;
		logic [31:0]    timer;
		sbt_login_type  login;
		logic [15:0]    node;
		logic [1:0]     speed;
		logic           permit;
		logic           unsol_pend;
		logic           async_pend;
		logic           status_valid;
		sbt_status_type status;
		logic           refused;
		logic           logout;
		logic           wd_restart;
		logic           guid_fetch;
		logic           retransmit;
		logic           resume;
		logic           iso_continue;
	} sbt_regs_type;

	sbt_regs_type s;
	sbt_regs_type next_s;

	// fills a status block; length follows whether exception words exist
	function automatic sbt_status_type make_status(
		input logic [47:0] addr,
		input logic [1:0]  src,
		input logic [7:0]  sbp,
		input logic [47:0] orb,
		input logic        full,
		input logic [15:0] cmd_dep,
		input logic [7:0]  code,
		input logic [15:0] code_dep
	);
		sbt_status_type b;
		b = '0;
		b.addr = addr;
		b.quads = full ? `SBT_LEN_FULL : `SBT_LEN_SHORT;
		b.src = src;
		b.resp = `SBT_RESP_COMPLETE;
		b.sbp = sbp;
		b.orb = orb;
		if (full) begin
			b.cmd_dep = cmd_dep;
			b.code = code;
			b.code_dep = code_dep;
		end
		return b;
	endfunction

	always_comb begin
		next_s = s;
		next_s.status_valid = 1'b0;
		next_s.refused = 1'b0;
		next_s.logout = 1'b0;
		next_s.wd_restart = 1'b0;
		next_s.guid_fetch = 1'b0;
		next_s.resume = 1'b0;
		next_s.retransmit = ack_crc_err;
		next_s.iso_continue = iso_active && (s.state != SBT_IDLE);

		// timer runs only inside the reconnect window
		if (s.state == SBT_WAIT_RECON || s.state == SBT_VERIFY) begin
			next_s.timer = s.timer + 32'h00000001;
		end

		unique case (s.state)
			SBT_IDLE: begin
				if (login_ok) begin
					next_s.state = SBT_ACTIVE;
					next_s.login = login_info;
					next_s.node = login_info.status_addr[`SBT_NODE_HI:`SBT_NODE_LO];
					next_s.permit = 1'b0;
					next_s.unsol_pend = 1'b0;
				end
			end
			SBT_ACTIVE: begin
				if (orb_req) begin
					next_s.status_valid = 1'b1;
					// unsupported type answered complete with status one
					next_s.status = make_status(s.login.status_addr,
						orb_info.next_null ? `SBT_SRC_LAST : `SBT_SRC_LINKED,
						orb_info.supported ? `SBT_ST_NONE : `SBT_ST_REQ_TYPE,
						orb_info.offset, orb_info.exception,
						orb_info.cmd_dep, orb_info.code, orb_info.code_dep);
				end else if (s.unsol_pend && s.permit) begin
					// unsolicited status to login status address
					next_s.status_valid = 1'b1;
					next_s.status = make_status(s.login.status_addr, `SBT_SRC_UNSOL,
						`SBT_ST_NONE, 48'h000000000000, 1'b0,
						16'h0000, 8'h00, 16'h0000);
					next_s.unsol_pend = 1'b0;
					next_s.permit = 1'b0;
				end
			end
			SBT_WAIT_RECON: begin
				// login identifier must match the stored one
				if (recon_req && recon_info.login_id == s.login.login_id) begin
					next_s.state = SBT_VERIFY;
					// session speed from the reconnect write
					next_s.speed = recon_info.speed;
					next_s.status.addr = recon_info.status_addr;
					next_s.guid_fetch = 1'b1;
				end else if (recon_req) begin
					next_s.status_valid = 1'b1;
					next_s.status = make_status(recon_info.status_addr, `SBT_SRC_LAST,
						`SBT_ST_LOGIN_ID, 48'h000000000000, 1'b0,
						16'h0000, 8'h00, 16'h0000);
				end
			end
			SBT_VERIFY: begin
				if (guid_valid) begin
					next_s.status_valid = 1'b1;
					if (host_guid == s.login.guid) begin
						next_s.state = SBT_ACTIVE;
						next_s.timer = '0;
						// completion goes to the reconnect buffer
						next_s.status = make_status(s.status.addr, `SBT_SRC_LAST,
							`SBT_ST_NONE, 48'h000000000000, 1'b0,
							16'h0000, 8'h00, 16'h0000);
						// new node and bus into stored addresses
						next_s.login.status_addr[`SBT_NODE_HI:`SBT_NODE_LO] = host_node;
						next_s.node = host_node;
						next_s.wd_restart = 1'b1;
						next_s.resume = s.async_pend;
						next_s.async_pend = 1'b0;
					end else begin
						// foreign host refused, window stays open
						next_s.state = SBT_WAIT_RECON;
						next_s.status = make_status(s.status.addr, `SBT_SRC_LAST,
							`SBT_ST_DENIED, 48'h000000000000, 1'b0,
							16'h0000, 8'h00, 16'h0000);
					end
				end
			end
		endcase

		// requests wait for the permit; one arriving as another is sent stays pending
		if (unsol_req && s.state == SBT_ACTIVE) begin
			next_s.unsol_pend = 1'b1;
		end

		// a login is held, so a fresh login is turned away
		if (login_req && s.state != SBT_IDLE) begin
			next_s.refused = 1'b1;
		end

		// window closed without reconnect, session dropped
		if ((s.state == SBT_WAIT_RECON || s.state == SBT_VERIFY) && s.timer == RECON_LAST
			&& !(s.state == SBT_VERIFY && guid_valid && host_guid == s.login.guid)) begin
			next_s.state = SBT_IDLE;
			next_s.timer = '0;
			next_s.login = '0;
			next_s.node = '0;
			next_s.speed = `SBT_SPD_S100;
			next_s.permit = 1'b0;
			next_s.unsol_pend = 1'b0;
			next_s.async_pend = 1'b0;
			next_s.logout = 1'b1;
		end

		// watchdog restarted on every bus reset
		if (bus_reset) begin
			next_s.wd_restart = 1'b1;
			// reset with a login opens the window; a logout this cycle leaves none held
			if (s.state != SBT_IDLE && !next_s.logout) begin
				next_s.resume = 1'b0;
				next_s.state = SBT_WAIT_RECON;
				next_s.timer = '0;
				next_s.async_pend = s.async_pend || async_active;
				next_s.status_valid = 1'b0;
			end
		end

		// permit write wins over the clear in the same cycle
		if (permit_set && s.state != SBT_IDLE) begin
			next_s.permit = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign status_valid = s.status_valid;
	assign status = s.status;
	assign state = s.state;
	assign speed = s.speed;
	assign data_node = s.node;
	assign guid_fetch = s.guid_fetch;
	assign login_refused = s.refused;
	assign logout = s.logout;
	assign wd_restart = s.wd_restart;
	assign retransmit = s.retransmit;
	assign async_resume = s.resume;
	assign iso_continue = s.iso_continue;

	unsup_orb_a: assert property (@(posedge core_clk) disable iff (rst)
		s.state == SBT_ACTIVE && orb_req && !orb_info.supported && !bus_reset
		|=> status_valid && status.sbp == `SBT_ST_REQ_TYPE && status.resp == `SBT_RESP_COMPLETE)
		else $error("unsupported request not answered with status one");

	block_len_a: assert property (@(posedge core_clk) disable iff (rst)
		status_valid |-> status.quads == `SBT_LEN_SHORT || status.quads == `SBT_LEN_FULL)
		else $error("status block length illegal");

	reset_window_a: assert property (@(posedge core_clk) disable iff (rst)
		bus_reset && state != SBT_IDLE && !(state != SBT_ACTIVE && s.timer == RECON_LAST)
		|=> state == SBT_WAIT_RECON && s.timer == 32'h00000000)
		else $error("bus reset did not open reconnect window");

	reset_watchdog_a: assert property (@(posedge core_clk) disable iff (rst)
		bus_reset |=> wd_restart)
		else $error("bus reset did not restart watchdog");

	login_refuse_a: assert property (@(posedge core_clk) disable iff (rst)
		login_req && state == SBT_WAIT_RECON |=> login_refused)
		else $error("login accepted inside reconnect window");

	guid_check_a: assert property (@(posedge core_clk) disable iff (rst)
		state == SBT_VERIFY && guid_valid && host_guid != s.login.guid && !bus_reset
		&& s.timer != RECON_LAST |=> state == SBT_WAIT_RECON && status.sbp == `SBT_ST_DENIED)
		else $error("foreign host reconnect accepted");

	recon_done_a: assert property (@(posedge core_clk) disable iff (rst)
		state == SBT_VERIFY && guid_valid && host_guid == s.login.guid && !bus_reset
		|=> state == SBT_ACTIVE && wd_restart && status_valid
		&& s.login.status_addr[`SBT_NODE_HI:`SBT_NODE_LO] == $past(host_node))
		else $error("reconnect completion wrong");

	expiry_logout_a: assert property (@(posedge core_clk) disable iff (rst)
		state == SBT_WAIT_RECON && s.timer == RECON_LAST && !bus_reset
		|=> logout && state == SBT_IDLE ##1 !logout)
		else $error("window expiry did not log out");

	unsol_permit_a: assert property (@(posedge core_clk) disable iff (rst)
		status_valid && status.src == `SBT_SRC_UNSOL |-> $past(s.permit)
		&& status.addr == s.login.status_addr)
		else $error("unsolicited status sent without permit");

	crc_retry_a: assert property (@(posedge core_clk) disable iff (rst)
		ack_crc_err |=> retransmit)
		else $error("crc error not retransmitted");

	speed_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		state == SBT_WAIT_RECON && recon_req && recon_info.login_id == s.login.login_id
		&& !bus_reset && s.timer != RECON_LAST |=> speed == $past(recon_info.speed) && guid_fetch)
		else $error("reconnect speed not taken");

	iso_keep_a: assert property (@(posedge core_clk) disable iff (rst)
		state != SBT_IDLE |=> iso_continue == $past(iso_active))
		else $error("isochronous stream not kept through reset");

	async_resume_a: assert property (@(posedge core_clk) disable iff (rst)
		state == SBT_VERIFY && guid_valid && host_guid == s.login.guid && !bus_reset
		|=> async_resume == $past(s.async_pend) && !s.async_pend)
		else $error("async phase resume wrong");

	idle_reset_a: assert property (@(posedge core_clk) disable iff (rst)
		bus_reset && state == SBT_IDLE && !login_ok |=> state == SBT_IDLE && wd_restart)
		else $error("bus reset without login opened window");

	unsol_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		unsol_req && state == SBT_ACTIVE |=> s.unsol_pend)
		else $error("unsolicited request lost");

endmodule

`default_nettype wire

// ==== hw/sbt_defs.svh ====
// constants of the serial-bus target session block: status codes, block
// lengths, speed codes and reconnect timing; included by package and module
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

`define SBT_ST_NONE       8'h00
`define SBT_ST_REQ_TYPE   8'h01
`define SBT_ST_SPEED      8'h02
`define SBT_ST_PAGE       8'h03
`define SBT_ST_DENIED     8'h04
`define SBT_ST_LUN        8'h05
`define SBT_ST_PAYLOAD    8'h06
`define SBT_ST_CHANNELS   8'h07
`define SBT_ST_RESOURCES  8'h08
`define SBT_ST_REJECTED   8'h09
`define SBT_ST_LOGIN_ID   8'h0A
`define SBT_ST_DUMMY      8'h0B
`define SBT_ST_ABORTED    8'h0C
`define SBT_ST_UNSPEC     8'hFF

// response code, source code and block lengths in quadlets
`define SBT_RESP_COMPLETE 2'h0
`define SBT_SRC_LINKED    2'h0
`define SBT_SRC_LAST      2'h1
`define SBT_SRC_UNSOL     2'h2
`define SBT_LEN_SHORT     3'h2
`define SBT_LEN_FULL      3'h5

// speed codes of the host write
`define SBT_SPD_S100      2'h0
`define SBT_SPD_S200      2'h1
`define SBT_SPD_S400      2'h2

// node field position inside a 48-bit bus address
`define SBT_NODE_HI       47
`define SBT_NODE_LO       32

// reconnect window in milliseconds and clock rate in kHz
`define SBT_RECON_MS      2000
`define SBT_CLK_KHZ       40000

`endif

// ==== hw/sbt_pkg.sv ====
// types of the serial-bus target session block
// assumes sbt_defs.svh sits next to this file
`include "sbt_defs.svh"

package sbt_pkg;

	typedef enum logic [1:0] {
		SBT_IDLE,
		SBT_ACTIVE,
		SBT_WAIT_RECON,
		SBT_VERIFY
	} sbt_state_type;

	typedef struct packed {
		logic [15:0] login_id;
		logic [63:0] guid;
		logic [47:0] status_addr;
	} sbt_login_type;

	typedef struct packed {
		logic [15:0] login_id;
		logic [1:0]  speed;
		logic [47:0] status_addr;
	} sbt_recon_type;

	typedef struct packed {
		logic [47:0] offset;
		logic        next_null;
		logic        supported;
		logic        exception;
		logic [15:0] cmd_dep;
		logic [7:0]  code;
		logic [15:0] code_dep;
	} sbt_orb_type;

	typedef struct packed {
		logic [47:0] addr;
		logic [2:0]  quads;
		logic [1:0]  src;
		logic [1:0]  resp;
		logic        dead;
		logic [7:0]  sbp;
		logic [47:0] orb;
		logic [15:0] cmd_dep;
		logic [7:0]  code;
		logic [15:0] code_dep;
	} sbt_status_type;

endpackage

// ==== bench/sbt_host_model.sv ====
// host stand-in: answers each bus info fetch with its unique id and node
// assumes every pin is sampled on rising core_clk
`timescale 1ns/1ps
`default_nettype none

module sbt_host_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        guid_fetch,
	input  wire logic [3:0]  delay,
	input  wire logic [63:0] guid_cfg,
	input  wire logic [15:0] node_cfg,
	output var  logic        guid_valid,
	output var  logic [63:0] host_guid,
	output var  logic [15:0] host_node
);
	// identity answer
	// after an answer the lines carry its inverse, so a late sample differs from the answer
	initial begin
		guid_valid = 1'h0;
		host_guid  = 64'h0;
		host_node  = 16'h0;
		forever begin
			@(posedge core_clk);
			if (rst === 1'h0 && guid_fetch === 1'h1) begin
				repeat (delay) @(posedge core_clk);
				#1;
				guid_valid = 1'h1;
				host_guid  = guid_cfg;
				host_node  = node_cfg;
				@(posedge core_clk);
				#1;
				guid_valid = 1'h0;
				host_guid  = ~host_guid;
				host_node  = ~host_node;
			end
		end
	end
endmodule

`default_nettype wire

// ==== bench/sbt_session_tb.sv ====
// self-checking bench of the session keeper, one task per scenario
// assumes sbt_pkg and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none

module sbt_session_tb;
	import sbt_pkg::*;
	localparam int RC = 20;
	localparam logic [47:0] LA = 48'hFFC0_0000_5000;
	localparam logic [47:0] RA = 48'hFFC0_0000_6000;
	localparam logic [15:0] HN = 16'hFFC2;
	localparam logic [63:0] GD = 64'h0011_2233_4455_6677;
	logic           core_clk, rst, bus_reset, login_ok, login_req, recon_req;
	logic           guid_valid, guid_fetch, orb_req, permit_set, unsol_req, ack_crc_err;
	logic           iso_active, async_active, status_valid, login_refused, logout;
	logic           wd_restart, retransmit, async_resume, iso_continue;
	logic [63:0]    host_guid, hg;
	logic [15:0]    host_node, data_node;
	logic [1:0]     speed;
	logic [3:0]     dly;
	sbt_login_type  login_info;
	sbt_recon_type  recon_info;
	sbt_orb_type    orb_info;
	sbt_status_type status;
	sbt_state_type  state;
	int             fails, comparisons, n;

	sbt_session #(.RECON_CYCLES(RC)) uut (.core_clk(core_clk), .rst(rst), .bus_reset(bus_reset),
		.login_ok(login_ok), .login_info(login_info), .login_req(login_req), .recon_req(recon_req),
		.recon_info(recon_info), .guid_valid(guid_valid), .host_guid(host_guid), .host_node(host_node),
		.orb_req(orb_req), .orb_info(orb_info), .permit_set(permit_set), .unsol_req(unsol_req),
		.ack_crc_err(ack_crc_err), .iso_active(iso_active), .async_active(async_active),
		.status_valid(status_valid), .status(status), .state(state), .speed(speed), .data_node(data_node),
		.guid_fetch(guid_fetch), .login_refused(login_refused), .logout(logout), .wd_restart(wd_restart),
		.retransmit(retransmit), .async_resume(async_resume), .iso_continue(iso_continue));

	sbt_host_model host (.core_clk(core_clk), .rst(rst), .guid_fetch(guid_fetch), .delay(dly),
		.guid_cfg(hg), .node_cfg(HN), .guid_valid(guid_valid), .host_guid(host_guid),
		.host_node(host_node));

	initial begin
		core_clk = 1'h0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step;
		@(posedge core_clk);
		#1;
	endtask

	task automatic pulse(ref logic s);
		@(posedge core_clk);
		#1 s = 1'h1;
		@(posedge core_clk);
		#1 s = 1'h0;
	endtask

	task automatic wait_status;
		n = 0;
		while (status_valid !== 1'h1 && n < 12) begin
			step();
			n++;
		end
	endtask

	task automatic t_login;
		login_info = '{login_id: 16'h0007, guid: GD, status_addr: LA};
		pulse(login_ok);
		chk("login_state", state, SBT_ACTIVE);
		$display("test login done");
	endtask

	task automatic t_expiry;
		pulse(bus_reset);
		n = 0;
		while (logout !== 1'h1 && n < RC + 5) begin
			step();
			n++;
		end
		chk("expiry_cycles", n, RC);
		chk("expiry_state", state, SBT_IDLE);
		pulse(orb_req);
		chk("orb_after_logout", status_valid, 1'h0);
		pulse(login_req);
		chk("retry_refused", login_refused, 1'h0);
		pulse(bus_reset);
		chk("idle_reset_wd", wd_restart, 1'h1);
		chk("idle_reset_state", state, SBT_IDLE);
		$display("test expiry done");
	endtask

	task automatic t_mismatch;
		pulse(bus_reset);
		recon_info = '{login_id: 16'h0009, speed: 2'h0, status_addr: RA};
		pulse(recon_req);
		chk("bad_id_code", status.sbp, 8'h0A);
		chk("bad_id_state", state, SBT_WAIT_RECON);
		hg = ~GD;
		recon_info.login_id = 16'h0007;
		pulse(recon_req);
		wait_status();
		chk("bad_guid_code", status.sbp, 8'h04);
		chk("bad_guid_state", state, SBT_WAIT_RECON);
		hg = GD;
		$display("test mismatch done");
	endtask

	task automatic t_recon(input logic [1:0] spd, input logic [3:0] d, input logic asy, input logic iso);
		async_active = asy;
		iso_active = iso;
		dly = d;
		pulse(bus_reset);
		chk("reset_wd", wd_restart, 1'h1);
		chk("reset_state", state, SBT_WAIT_RECON);
		pulse(login_req);
		chk("refused", login_refused, 1'h1);
		recon_info = '{login_id: 16'h0007, speed: spd, status_addr: RA};
		pulse(recon_req);
		chk("fetch", guid_fetch, 1'h1);
		chk("speed", speed, spd);
		wait_status();
		chk("recon_addr", status.addr, RA);
		chk("recon_code", status.sbp, 8'h00);
		chk("recon_wd", wd_restart, 1'h1);
		chk("recon_state", state, SBT_ACTIVE);
		chk("resume", async_resume, asy);
		chk("data_node", data_node, HN);
		chk("iso_continue", iso_continue, iso);
		$display("test reconnect done");
	endtask

	task automatic t_orb;
		orb_info = '{offset: 48'h0000_0000_A000, next_null: 1'h0, supported: 1'h0, exception: 1'h0,
			cmd_dep: 16'h1111, code: 8'h22, code_dep: 16'h3333};
		pulse(orb_req);
		chk("orb_valid", status_valid, 1'h1);
		chk("orb_sbp", status.sbp, 8'h01);
		chk("orb_resp", status.resp, 2'h0);
		chk("orb_quads", status.quads, 3'h2);
		chk("orb_cmd", status.cmd_dep, 16'h0);
		chk("orb_addr", status.addr, {HN, LA[31:0]});
		orb_info.next_null = 1'h1;
		orb_info.supported = 1'h1;
		orb_info.exception = 1'h1;
		pulse(orb_req);
		chk("exc_quads", status.quads, 3'h5);
		chk("exc_sbp", status.sbp, 8'h00);
		chk("exc_src", status.src, 2'h1);
		chk("exc_words", {status.cmd_dep, status.code, status.code_dep}, 40'h1111_2233_33);
		chk("exc_orb", status.orb, 48'h0000_0000_A000);
		$display("test orb done");
	endtask

	task automatic t_unsol;
		pulse(unsol_req);
		step();
		chk("no_permit", status_valid, 1'h0);
		pulse(permit_set);
		step();
		chk("unsol_valid", status_valid, 1'h1);
		chk("unsol_src", status.src, 2'h2);
		chk("unsol_addr", status.addr, {HN, LA[31:0]});
		chk("unsol_orb", status.orb, 48'h0);
		pulse(unsol_req);
		step();
		chk("permit_used", status_valid, 1'h0);
		pulse(ack_crc_err);
		chk("retransmit", retransmit, 1'h1);
		$display("test unsolicited done");
	endtask

	task automatic print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (4000) @(posedge core_clk);
		fails++;
		print_verdict();
	end

	initial begin
		{rst, bus_reset, login_ok, login_req, recon_req, orb_req} = 6'h20;
		{permit_set, unsol_req, ack_crc_err, iso_active, async_active} = 5'h0;
		login_info = '0;
		recon_info = '0;
		orb_info = '0;
		hg = GD;
		dly = 4'h0;
		repeat (12) @(posedge core_clk);
		#1 rst = 1'h0;
		t_login();
		t_expiry();
		t_login();
		t_mismatch();
		t_recon(2'h0, 4'h0, 1'h1, 1'h0);
		t_recon(2'h1, 4'h2, 1'h0, 1'h1);
		t_recon(2'h2, 4'h0, 1'h0, 1'h0);
		t_orb();
		t_unsol();
		print_verdict();
	end
endmodule

`default_nettype wire
